// ---- include/fsync_pkg.sv ----
// Purpose: Shared constants for the frame-synchronised converter serial port
// Assumes: Both ends run on a 25 MHz system clock
// Notes: Serial cycle numbers count serial clock rising edges after frame sync
package fsync_pkg;
    localparam int SYS_CLK_NS = 40;
    localparam int SCLK_PERIOD_NS = 640;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_CLK_NS);
    localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);
    localparam logic [5:0] CFG_BITS_8 = 6'h08;
    localparam logic [5:0] CFG_BITS_16 = 6'h10;
    localparam logic [5:0] CH_SEL_CYC = 6'h03;
    localparam logic [5:0] SAMPLE_CYC_8 = 6'h07;
    localparam logic [5:0] SAMPLE_CYC_16 = 6'h0F;
    localparam logic [5:0] RESULT_BITS = 6'h10;
    localparam logic [5:0] TOTAL_CYC_8 = 6'h18;
    localparam logic [5:0] TOTAL_CYC_16 = 6'h20;
    localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

// ---- include/fsync_if.sv ----
// Purpose: Serial link between the converter port and the DSP host
// Assumes: Every wire has exactly one driving end
// Notes: No clocking block; both ends sample through synchronisers
`timescale 1ns/1ps
interface fsync_if;
    logic sclk;
    logic cs_n;
    logic frame_sync_in;
    logic din;
    logic width_select;
    logic frame_sync_out;
    logic dout;
    modport dev (input sclk, input cs_n, input frame_sync_in, input din, input width_select,
                 output frame_sync_out, output dout);
    modport host (output sclk, output cs_n, output frame_sync_in, output din, output width_select,
                  input frame_sync_out, input dout);
endinterface

// ---- hw/fsync_dsp_host.sv ----
// Purpose: DSP-side end: makes the serial clock and runs frame-sync transfers
// Assumes: Serial clock derived from sys_clk by a divider
// Notes: Read data is sampled at the end of each low phase, well after the device updates
`timescale 1ns/1ps
module fsync_dsp_host
    import fsync_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    fsync_if.host port,
    input wire logic start,
    input wire logic release_link,
    input wire logic wide,
    input wire logic [15:0] cfg_word,
    output logic [15:0] result,
    output logic result_valid,
    output logic busy
);
    typedef enum logic [2:0] {H_IDLE = 3'b001, H_ENTER = 3'b010, H_RUN = 3'b100} host_state_t;
    host_state_t state_ff;
    logic [3:0] div_ff;
    logic [5:0] cnt_ff;
    logic [15:0] cfg_sr_ff;
    logic mode_ff;
    logic sclk_ff, cs_n_ff, fsync_ff, din_ff, width_ff;
    logic [1:0] dout_meta_ff, dout_sync_ff;
    logic [5:0] last_cyc;
    logic [5:0] cfg_bits;
    logic tick;

    assign tick = (div_ff == SCLK_HALF_LAST);
    assign last_cyc = width_ff ? TOTAL_CYC_16 : TOTAL_CYC_8;
    assign cfg_bits = width_ff ? CFG_BITS_16 : CFG_BITS_8;

    assign port.sclk = sclk_ff;
    assign port.cs_n = cs_n_ff;
    assign port.frame_sync_in = fsync_ff;
    assign port.din = din_ff;
    assign port.width_select = width_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_meta_ff <= 2'h0;
            dout_sync_ff <= 2'h0;
        end else if (clk_en) begin
            dout_meta_ff <= {port.frame_sync_out, port.dout};
            dout_sync_ff <= dout_meta_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 4'h0;
        end else if (clk_en) begin
            div_ff <= (state_ff == H_IDLE || tick) ? 4'h0 : div_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= H_IDLE;
            mode_ff <= 1'b0;
            cnt_ff <= 6'h00;
            cfg_sr_ff <= WORD_RST;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            fsync_ff <= 1'b0;
            din_ff <= 1'b0;
            width_ff <= 1'b0;
            result <= WORD_RST;
            result_valid <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            result_valid <= 1'b0;
            case (state_ff)
                H_IDLE: begin
                    sclk_ff <= 1'b0;
                    if (release_link) begin
                        cs_n_ff <= 1'b1;
                        mode_ff <= 1'b0;
                    end else if (start) begin
                        width_ff <= wide;
                        cfg_sr_ff <= wide ? cfg_word : {cfg_word[7:0], 8'h00};
                        cnt_ff <= 6'h00;
                        busy <= 1'b1;
                        if (!mode_ff) begin
                            cs_n_ff <= 1'b0;
                            mode_ff <= 1'b1;
                            state_ff <= H_ENTER;
                        end else begin
                            fsync_ff <= 1'b1;
                            state_ff <= H_RUN;
                        end
                    end
                end
                H_ENTER: begin
                    if (tick) begin
                        fsync_ff <= 1'b1;
                        state_ff <= H_RUN;
                    end
                end
                H_RUN: begin
                    if (tick && sclk_ff) begin
                        sclk_ff <= 1'b0;
                        // Sync drops with the fall of cycle 0, so the device counts from the next rise
                        fsync_ff <= 1'b0;
                    end else if (tick) begin
                        if (cnt_ff > cfg_bits && cnt_ff <= last_cyc) begin
                            result <= {result[14:0], dout_sync_ff[0]};
                        end
                        if (cnt_ff == last_cyc) begin
                            result_valid <= 1'b1;
                            busy <= 1'b0;
                            din_ff <= 1'b0;
                            state_ff <= H_IDLE;
                        end else begin
                            sclk_ff <= 1'b1;
                            // Cycle 0 carries only the sync pulse; a bit sent there would be lost
                            if (!fsync_ff) begin
                                cnt_ff <= cnt_ff + 6'h01;
                                din_ff <= cfg_sr_ff[15];
                                cfg_sr_ff <= {cfg_sr_ff[14:0], 1'b0};
                            end
                        end
                    end
                end
                default: state_ff <= H_IDLE;
            endcase
        end
    end
endmodule // fsync_dsp_host

// ---- hw/fsync_adc_dev.sv ----
// Purpose: Converter-side end of the frame-synchronised serial port
// Assumes: Link pins are asynchronous to sys_clk and pass two flip-flops
// Notes: Analog section is modelled by sample_code; sclk must be well below sys_clk/4
`timescale 1ns/1ps
module fsync_adc_dev
    import fsync_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    fsync_if.dev port,
    input wire logic [15:0] sample_code,
    output logic [15:0] cfg_word,
    output logic cfg_valid,
    output logic acq_active,
    output logic sample_taken,
    output logic dsp_mode,
    output logic shutdown
);
    typedef enum logic [3:0] {
        S_SHUT = 4'b0001,
        S_WAKE = 4'b0010,
        S_RUN = 4'b0100,
        S_DONE = 4'b1000
    } dev_state_t;

    dev_state_t state_ff;
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;
    logic [4:0] pin_prev_ff;
    logic sclk_s, cs_n_s, fsync_s, din_s, width_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, fs_rise, fs_fall;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic wide_ff;
    logic [15:0] cfg_sr_ff;
    logic [15:0] out_sr_ff;
    logic dout_ff;
    logic fso_ff;
    logic [5:0] cfg_bits, sample_cyc, last_cyc;

    // Bit order: sclk, cs_n, frame_sync_in, din, width_select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 5'h02;
            pin_sync_ff <= 5'h02;
            pin_prev_ff <= 5'h02;
        end else if (clk_en) begin
            pin_meta_ff <= {port.width_select, port.din, port.frame_sync_in, port.cs_n, port.sclk};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign sclk_s = pin_sync_ff[0];
    assign cs_n_s = pin_sync_ff[1];
    assign fsync_s = pin_sync_ff[2];
    assign din_s = pin_sync_ff[3];
    assign width_s = pin_sync_ff[4];
    assign sclk_rise = sclk_s && !pin_prev_ff[0];
    assign sclk_fall = !sclk_s && pin_prev_ff[0];
    assign cs_fall = !cs_n_s && pin_prev_ff[1];
    assign cs_rise = cs_n_s && !pin_prev_ff[1];
    assign fs_rise = fsync_s && !pin_prev_ff[2];
    assign fs_fall = !fsync_s && pin_prev_ff[2];
    assign nxt_cnt = cnt_ff + 6'h01;

    // Width is held per frame so a mid-frame change cannot skew the bit counts
    assign cfg_bits = wide_ff ? CFG_BITS_16 : CFG_BITS_8;
    assign sample_cyc = wide_ff ? SAMPLE_CYC_16 : SAMPLE_CYC_8;
    assign last_cyc = wide_ff ? TOTAL_CYC_16 : TOTAL_CYC_8;

    assign port.frame_sync_out = fso_ff;
    assign port.dout = dout_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dsp_mode <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                dsp_mode <= !fsync_s;
            end else if (cs_rise) begin
                dsp_mode <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_SHUT;
            cnt_ff <= 6'h00;
            wide_ff <= 1'b0;
        end else if (clk_en) begin
            if (cs_n_s) begin
                state_ff <= S_SHUT;
                cnt_ff <= 6'h00;
            end else if (dsp_mode && fs_rise) begin
                state_ff <= S_WAKE;
                cnt_ff <= 6'h00;
            end else begin
                case (state_ff)
                    S_SHUT: state_ff <= S_SHUT;
                    S_WAKE: begin
                        if (fs_fall) begin
                            wide_ff <= width_s;
                            cnt_ff <= 6'h00;
                            state_ff <= S_RUN;
                        end
                    end
                    S_RUN: begin
                        if (sclk_rise) begin
                            cnt_ff <= nxt_cnt;
                            if (nxt_cnt == last_cyc) begin
                                state_ff <= S_DONE;
                            end
                        end
                    end
                    // Stays here through cs low until the next sync, no toggle needed
                    S_DONE: state_ff <= S_DONE;
                    default: state_ff <= S_SHUT;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_sr_ff <= WORD_RST;
            cfg_word <= WORD_RST;
            cfg_valid <= 1'b0;
        end else if (clk_en) begin
            cfg_valid <= 1'b0;
            if (state_ff == S_RUN && sclk_fall && cnt_ff != 6'h00 && cnt_ff <= cfg_bits) begin
                cfg_sr_ff <= {cfg_sr_ff[14:0], din_s};
                if (cnt_ff == cfg_bits) begin
                    cfg_word <= {cfg_sr_ff[14:0], din_s};
                    cfg_valid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acq_active <= 1'b0;
            sample_taken <= 1'b0;
            out_sr_ff <= WORD_RST;
        end else if (clk_en) begin
            sample_taken <= 1'b0;
            if (state_ff != S_RUN) begin
                acq_active <= 1'b0;
            end else if (sclk_fall && cnt_ff == CH_SEL_CYC) begin
                acq_active <= 1'b1;
            end else if (sclk_rise && nxt_cnt == sample_cyc) begin
                acq_active <= 1'b0;
                sample_taken <= 1'b1;
                out_sr_ff <= sample_code;
            end else if (sclk_rise && nxt_cnt > cfg_bits) begin
                // Zero fill means clocks past the result shift out zeros
                out_sr_ff <= {out_sr_ff[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'b0;
            fso_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == S_RUN && sclk_rise) begin
                fso_ff <= (nxt_cnt == cfg_bits);
                dout_ff <= (nxt_cnt > cfg_bits) ? out_sr_ff[15] : 1'b0;
            end else if (state_ff == S_DONE && sclk_rise) begin
                dout_ff <= 1'b0;
            end else if (state_ff == S_SHUT || state_ff == S_WAKE) begin
                dout_ff <= 1'b0;
                fso_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown <= 1'b1;
        end else if (clk_en) begin
            shutdown <= (state_ff == S_SHUT);
        end
    end
endmodule // fsync_adc_dev

// ---- tb/fsync_link_assertions.sv ----
// Purpose: Timing checks on the host-to-converter frame-sync link
// Assumes: All link pins are flops of sys_clk, so one domain suffices
// Notes: Serial cycles are counted from the sync fall, as the device counts them
`timescale 1ns/1ps
module fsync_link_assertions
    import fsync_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic frame_sync_in,
    input wire logic din,
    input wire logic width_select,
    input wire logic frame_sync_out,
    input wire logic dout
);
    logic sclk_ff, sync_ff, wide_ff, in_frame_ff, rise, sfall;
    logic [5:0] cnt_ff, wcyc;
    assign rise = sclk && !sclk_ff;
    assign sfall = sync_ff && !frame_sync_in;
    assign wcyc = wide_ff ? CFG_BITS_16 : CFG_BITS_8;
    // Width taken at the sync fall so a width change between frames is safe; count saturates when idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_ff <= 1'b0;
            sync_ff <= 1'b0;
            wide_ff <= 1'b0;
            in_frame_ff <= 1'b0;
            cnt_ff <= 6'h00;
        end else begin
            sclk_ff <= sclk;
            sync_ff <= frame_sync_in;
            wide_ff <= sfall ? width_select : wide_ff;
            in_frame_ff <= !cs_n && (in_frame_ff || sfall);
            cnt_ff <= sfall ? 6'h00 : (rise && cnt_ff != 6'h3F) ? cnt_ff + 6'h01 : cnt_ff;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fso_hold;
        frame_sync_out [*8];
    endsequence
    mode_entry_a: assert property ($fell(cs_n) |-> !frame_sync_in)
        else $error("select fell with sync high");
    sync_first_a: assert property (rise && !in_frame_ff |-> frame_sync_in)
        else $error("serial clock outside a frame");
    din_stable_a: assert property ($fell(sclk) |-> $stable(din))
        else $error("data moved at latch edge");
    fso_start_a: assert property (rise && in_frame_ff && cnt_ff == wcyc - 6'h01 |-> ##[1:6] frame_sync_out)
        else $error("sync out missing");
    fso_hold_a: assert property ($rose(frame_sync_out) |-> s_fso_hold)
        else $error("sync out pulse too short");
    fso_window_a: assert property (frame_sync_out |-> cnt_ff == wcyc || cnt_ff == wcyc + 6'h01)
        else $error("sync out in wrong cycle");
    dout_quiet_a: assert property (in_frame_ff && cnt_ff >= 6'h02 && cnt_ff < wcyc |-> !dout)
        else $error("data out before result phase");
    frame_len_a: assert property ($rose(frame_sync_in) && in_frame_ff |-> cnt_ff == wcyc + RESULT_BITS)
        else $error("frame length wrong");
    shut_quiet_a: assert property ($rose(cs_n) |-> ##4 (!frame_sync_out) [*4])
        else $error("sync out after select rise");
endmodule // fsync_link_assertions

// ---- tb/dsp_framesync_adc_port_tb.sv ----
// Purpose: Self-checking bench for both ends of the frame-sync converter link
// Assumes: A second converter end faces bench-driven pins that break frames on purpose
// Notes: The bench-driven link clock has a 320 ns period
`timescale 1ns/1ps
module dsp_framesync_adc_port_tb
    import fsync_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic release_link = 1'b0;
    logic wide = 1'b0;
    logic z;
    logic [15:0] cfg_in = 16'h0000;
    logic [15:0] code = 16'h0000;
    logic [15:0] code_b = 16'hC3A5;
    logic [15:0] result, cfg_word, cfg_b, r;
    logic result_valid, busy, cfg_valid, acq_active, sample_taken, dsp_mode, shutdown, shutdown_b, mode_b;
    int err_total = 0;
    int n_checks = 0;
    int n_samp = 0;
    int n_acq = 0;
    int n_cfg = 0;
    int fp;
    fsync_if lk();
    fsync_if lk2();
    fsync_dsp_host u_fsync_dsp_host (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .port(lk), .start(start),
        .release_link(release_link), .wide(wide), .cfg_word(cfg_in), .result(result),
        .result_valid(result_valid), .busy(busy));
    fsync_adc_dev u_fsync_adc_dev (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .port(lk),
        .sample_code(code), .cfg_word(cfg_word), .cfg_valid(cfg_valid), .acq_active(acq_active),
        .sample_taken(sample_taken), .dsp_mode(dsp_mode), .shutdown(shutdown));
    // Second end: its pins come from the bench so that aborts can be forced
    fsync_adc_dev u_fsync_adc_dev_b (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .port(lk2),
        .sample_code(code_b), .cfg_word(cfg_b), .cfg_valid(), .acq_active(), .sample_taken(),
        .dsp_mode(mode_b), .shutdown(shutdown_b));
    fsync_link_assertions u_fsync_link_assertions (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(lk.sclk),
        .cs_n(lk.cs_n), .frame_sync_in(lk.frame_sync_in), .din(lk.din), .width_select(lk.width_select),
        .frame_sync_out(lk.frame_sync_out), .dout(lk.dout));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run(input logic w, input logic [15:0] cfg, input logic [15:0] c);
        int s;
        int a;
        int i;
        int g;
        s = n_samp;
        a = n_acq;
        g = n_cfg;
        wide = w;
        cfg_in = cfg;
        code = c;
        start = 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            start = 1'b0;
            i++;
        end while (result_valid !== 1'b1 && i < 3000);
        chk({15'h0000, result_valid}, 16'h0001, "result handshake");
        chk({15'h0000, busy}, 16'h0000, "busy after result");
        chk(16'(n_cfg - g), 16'h0001, "config strobe count");
        chk(result, c, "result word");
        chk(w ? cfg_word : {8'h00, cfg_word[7:0]}, w ? cfg : {8'h00, cfg[7:0]}, "config word");
        chk(16'(n_samp - s), 16'h0001, "sample count");
        chk(16'((n_acq - a) / 16), w ? 16'h000B : 16'h0003, "acquire span");
        chk({15'h0000, dsp_mode}, 16'h0001, "mode kept");
        $display("test width %0d done at %0t", w ? 16 : 8, $time);
    endtask
    // Bench link cycle: data set at the rise, outputs read just before the next rise
    task automatic tick(input logic d, output logic q, output logic f);
        lk2.sclk = 1'b1;
        lk2.din = d;
        #160;
        lk2.sclk = 1'b0;
        #158;
        q = lk2.dout;
        f = lk2.frame_sync_out;
        #2;
    endtask
    task automatic sync2;
        lk2.frame_sync_in = 1'b1;
        #320;
        lk2.sclk = 1'b1;
        #160;
        lk2.sclk = 1'b0;
        lk2.frame_sync_in = 1'b0;
        #160;
    endtask
    task automatic bframe(input int n, input logic [7:0] cf);
        logic q;
        logic f;
        r = 16'h0000;
        fp = 0;
        z = 1'b0;
        for (int k = 1; k <= n; k++) begin
            tick(k <= 8 ? cf[8 - k] : 1'b0, q, f);
            if (k > 8 && k <= 24) r = {r[14:0], q};
            if (k > 24) z = z | q;
            if (f === 1'b1 && fp == 0) fp = k;
        end
    endtask
    always @(negedge sys_clk) begin
        if (sample_taken === 1'b1) n_samp++;
        if (acq_active === 1'b1) n_acq++;
        if (cfg_valid === 1'b1) n_cfg++;
    end
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (25000) @(posedge sys_clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test;
    end
    initial begin
        lk2.sclk = 1'b0;
        lk2.cs_n = 1'b1;
        lk2.frame_sync_in = 1'b0;
        lk2.din = 1'b0;
        lk2.width_select = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        lk2.cs_n = 1'b0;
        @(posedge sys_clk);
        #1;
        run(1'b0, 16'h00A7, 16'hFFFF);
        run(1'b0, 16'h005A, 16'h0000);
        run(1'b1, 16'hB3C4, 16'h8001);
        run(1'b0, 16'h0081, 16'h7FFE);
        release_link = 1'b1;
        @(posedge sys_clk);
        #1;
        release_link = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        chk({14'h0000, shutdown, dsp_mode}, 16'h0002, "released link");
        run(1'b1, 16'h1234, 16'h4321);
        sync2;
        bframe(5, 8'h3C);
        sync2;
        bframe(26, 8'hA5);
        chk({8'h00, cfg_b[7:0]}, 16'h00A5, "config after restart");
        chk(r, code_b, "result after restart");
        chk(16'(fp), 16'h0008, "sync out cycle");
        chk({15'h0000, z}, 16'h0000, "trailing zeros");
        $display("test restart done at %0t", $time);
        sync2;
        bframe(4, 8'hFF);
        lk2.cs_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        chk({14'h0000, shutdown_b, mode_b}, 16'h0002, "select abort");
        $display("test select abort done at %0t", $time);
        stop_test;
    end
endmodule // dsp_framesync_adc_port_tb
